// >>> atm_axi_pm.sv
// Manager and subordinate pair driving one monitored slot.
// Assumes each call starts just after a rising clk edge.
`timescale 1ns/1ps
`include "atm_params.svh"
module atm_axi_pm (
  // Clock
  input wire logic          clk,
  // Monitored bus
  output atm_pkg::atm_axi_s axi
);
  typedef logic [`ATM_ID_W-1:0] atm_id_t;
  initial axi = '0;
  // ----------
  // Channel tasks; araddr, awaddr, rid and bid flip on release so stale values never match
  // ----------
  task automatic ar(input atm_id_t i, input logic [31:0] d, input int l);
    @(posedge clk);
    axi.arvalid <= 1'b1;
    axi.arid <= i;
    axi.araddr <= d;
    repeat (l) @(posedge clk);
    axi.arready <= 1'b1;
    @(posedge clk);
    axi.arvalid <= 1'b0;
    axi.arready <= 1'b0;
    axi.araddr <= ~d;
  endtask
  task automatic aw(input atm_id_t i, input logic [31:0] d);
    @(posedge clk);
    axi.awvalid <= 1'b1;
    axi.awready <= 1'b1;
    axi.awid <= i;
    axi.awaddr <= d;
    @(posedge clk);
    axi.awvalid <= 1'b0;
    axi.awaddr <= ~d;
  endtask
  task automatic r(input atm_id_t i, input int n);
    for (int k = 1; k <= n; k++)
    begin
      @(posedge clk);
      axi.rvalid <= 1'b1;
      axi.rready <= 1'b1;
      axi.rlast <= k == n;
      axi.rid <= i;
    end
    @(posedge clk);
    axi.rvalid <= 1'b0;
    axi.rid <= ~i;
  endtask
  task automatic w(input int n);
    for (int k = 1; k <= n; k++)
    begin
      @(posedge clk);
      axi.wvalid <= 1'b1;
      axi.wready <= 1'b1;
      axi.wlast <= k == n;
    end
    @(posedge clk);
    axi.wvalid <= 1'b0;
  endtask
  task automatic b(input atm_id_t i);
    @(posedge clk);
    axi.bvalid <= 1'b1;
    axi.bready <= 1'b1;
    axi.bid <= i;
    @(posedge clk);
    axi.bvalid <= 1'b0;
    axi.bid <= ~i;
  endtask
endmodule // atm_axi_pm

// >>> atm_evt.sv
// Per-slot channel event classifier.
// Assumes the monitored bus is sampled on the same clock as this module.
`timescale 1ns/1ps
`include "atm_params.svh"

module atm_evt (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Monitored bus and events
  input  wire atm_pkg::atm_axi_s axi,
  output atm_pkg::atm_evt_s     evt
);

  typedef struct packed {
    logic ar_wait;
    logic aw_wait;
    logic w_hs;
  } atm_evt_st_s;

  atm_evt_st_s st;
  atm_evt_st_s next_st;

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    evt.ar_start = axi.arvalid & ~st.ar_wait;
    evt.ar_cmd = axi.arvalid;
    evt.ar_end = axi.arvalid & axi.arready;
    evt.ar_idle = ~axi.arvalid;
    evt.r_beat = axi.rvalid & axi.rready & ~axi.rlast;
    evt.r_last = axi.rvalid & axi.rready & axi.rlast;
    evt.r_idle = ~(axi.rvalid & axi.rready);
    evt.aw_start = axi.awvalid & ~st.aw_wait;
    evt.aw_cmd = axi.awvalid;
    evt.aw_end = axi.awvalid & axi.awready;
    evt.aw_idle = ~axi.awvalid;
    // Only the first beat of a streaming burst is flagged
    evt.w_beat = axi.wvalid & axi.wready & ~axi.wlast & ~st.w_hs;
    evt.w_last = axi.wvalid & axi.wready & axi.wlast;
    evt.w_idle = ~(evt.w_beat | evt.w_last);
    evt.b_resp = axi.bvalid & axi.bready;
    evt.b_idle = ~evt.b_resp;
    next_st.ar_wait = axi.arvalid & ~axi.arready;
    next_st.aw_wait = axi.awvalid & ~axi.awready;
    next_st.w_hs = axi.wvalid & axi.wready;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

endmodule // atm_evt

// >>> atm_monitor.sv
// Top of the passive AXI transaction and event monitor.
// Assumes every monitored slot runs on CLK_SYS and registers are
// reached over an Avalon-MM slave with waitrequest.
`timescale 1ns/1ps
`include "atm_params.svh"

module atm_monitor #(
  parameter int NS     = 2,
  parameter int RD_OUT = `ATM_RD_OUT,
  parameter int WR_OUT = `ATM_WR_OUT,
  parameter int NCNT   = `ATM_NCNT,
  parameter int OPEN_N = `ATM_OPEN_N,
  parameter int DEPTH  = `ATM_DEPTH
) (
  // Clock and reset
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST,
  // Avalon-MM register slave
  input  wire logic [7:0]              AVS_ADDRESS,
  input  wire logic                    AVS_READ,
  input  wire logic                    AVS_WRITE,
  input  wire logic [31:0]             AVS_WRITEDATA,
  input  wire logic [3:0]              AVS_BYTEENABLE,
  output logic [31:0]                  AVS_READDATA,
  output logic                         AVS_WAITREQUEST,
  // Monitored slots
  input  wire atm_pkg::atm_axi_s [NS-1:0] AXI_MON,
  // Registered channel events
  output atm_pkg::atm_evt_s [NS-1:0]   EVT
);

  localparam int NK = NS * 2;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int DW = $clog2(DEPTH);

  typedef struct packed {
    atm_pkg::atm_bus_e                       bus;
    logic                                    en;
    logic                                    full;
    logic [NK*2-1:0]                         ovf;
    logic [CW-1:0]                           count;
    logic [DW-1:0]                           sel;
    logic [31:0]                             rdata;
    logic [`ATM_TS_W-1:0]                    ts;
    atm_pkg::atm_open_s [NK-1:0][OPEN_N-1:0] opn;
    atm_pkg::atm_evt_s [NS-1:0]              evt;
  } atm_mon_st_s;

  atm_mon_st_s                     st;
  atm_mon_st_s                     next_st;
  atm_pkg::atm_evt_s [NS-1:0]      evt_now;
  logic [NK-1:0]                   ovf_dep;
  logic [NK-1:0]                   ovf_ids;
  logic [NK-1:0]                   trk_opn;
  logic [NK-1:0]                   trk_cls;
  logic [NK-1:0][`ATM_ID_W-1:0]    trk_oid;
  logic [NK-1:0][`ATM_ID_W-1:0]    trk_cid;
  logic [NK-1:0]                   wen;
  logic [NK-1:0][DW-1:0]           widx;
  atm_pkg::atm_rec_s [NK-1:0]      recs;
  logic                            clr;
  logic [31:0]                     rd_word;
  atm_pkg::atm_rec_s               rec_sel;
  atm_pkg::atm_rec_s               mem [DEPTH];

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

  // ----------------------------------------
  // Slot classifiers and per-ID counters
  // ----------------------------------------
  // Read and write counters differ only in their capacity
  for (genvar s = 0; s < NS; s++)
  begin : g_slot
    atm_evt u_evt (
      .clk (CLK_SYS),
      .rst (RST),
      .axi (AXI_MON[s]),
      .evt (evt_now[s])
    );
    atm_trk #(.CAP(RD_OUT), .NCNT(NCNT)) u_rd (
      .clk       (CLK_SYS),
      .rst       (RST),
      .clr       (clr),
      .opn       (trk_opn[s*2]),
      .opn_id    (trk_oid[s*2]),
      .cls       (trk_cls[s*2]),
      .cls_id    (trk_cid[s*2]),
      .ovf_depth (ovf_dep[s*2]),
      .ovf_ids   (ovf_ids[s*2])
    );
    atm_trk #(.CAP(WR_OUT), .NCNT(NCNT)) u_wr (
      .clk       (CLK_SYS),
      .rst       (RST),
      .clr       (clr),
      .opn       (trk_opn[s*2+1]),
      .opn_id    (trk_oid[s*2+1]),
      .cls       (trk_cls[s*2+1]),
      .cls_id    (trk_cid[s*2+1]),
      .ovf_depth (ovf_dep[s*2+1]),
      .ovf_ids   (ovf_ids[s*2+1])
    );
  end

  // ----------------------------------------
  // Start and end events per slot and direction
  // ----------------------------------------
  always_comb
  begin
    for (int s = 0; s < NS; s++)
    begin
      trk_opn[s*2] = evt_now[s].ar_start;
      trk_oid[s*2] = AXI_MON[s].arid;
      trk_cls[s*2] = evt_now[s].r_last;
      trk_cid[s*2] = AXI_MON[s].rid;
      trk_opn[s*2+1] = evt_now[s].aw_start;
      trk_oid[s*2+1] = AXI_MON[s].awid;
      trk_cls[s*2+1] = evt_now[s].b_resp;
      trk_cid[s*2+1] = AXI_MON[s].bid;
    end
  end

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  always_comb
  begin
    logic [31:0] idle_v;
    idle_v = '0;
    for (int s = 0; s < NS; s++)
      idle_v[s*5 +: 5] = {st.evt[s].b_idle, st.evt[s].w_idle,
                          st.evt[s].aw_idle, st.evt[s].r_idle,
                          st.evt[s].ar_idle};
    rec_sel = mem[st.sel];
    case (AVS_ADDRESS)
      `ATM_OFS_CTRL:  rd_word = 32'(st.en);
      `ATM_OFS_STAT:  rd_word = {30'h0, st.full, st.en};
      `ATM_OFS_OVF:   rd_word = 32'(st.ovf);
      `ATM_OFS_CNT:   rd_word = 32'(st.count);
      `ATM_OFS_SEL:   rd_word = 32'(st.sel);
      `ATM_OFS_INFO:  rd_word = {16'(rec_sel.id), rec_sel.slot,
                                 7'h0, rec_sel.dir};
      `ATM_OFS_ADDR:  rd_word = rec_sel.addr;
      `ATM_OFS_START: rd_word = rec_sel.start;
      `ATM_OFS_END:   rd_word = rec_sel.fin;
      `ATM_OFS_DUR:   rd_word = rec_sel.dur;
      `ATM_OFS_IDLE:  rd_word = idle_v;
      default:        rd_word = 32'h0;
    endcase
  end

  // A clear that lands with an overflow still records the overflow
  assign clr = (st.bus == atm_pkg::BUS_ACK) && AVS_WRITE &&
               (AVS_ADDRESS == `ATM_OFS_CTRL) && AVS_BYTEENABLE[0] &&
               AVS_WRITEDATA[`ATM_CTRL_CLR];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    int k;
    int pick;
    int fr;
    int ptr;
    logic [31:0] wv;
    k = 0;
    pick = -1;
    fr = -1;
    ptr = 0;
    wv = '0;
    next_st = st;
    wen = '0;
    widx = '0;
    recs = '0;
    next_st.ts = st.ts + 1'b1;
    next_st.evt = evt_now;

    // Bus handshake: one wait cycle, then the answer
    case (st.bus)
      atm_pkg::BUS_WAIT:
      begin
        if (AVS_READ || AVS_WRITE)
        begin
          next_st.bus = atm_pkg::BUS_ACK;
          next_st.rdata = rd_word;
        end
      end
      atm_pkg::BUS_ACK:
      begin
        next_st.bus = atm_pkg::BUS_WAIT;
        if (AVS_WRITE && AVS_ADDRESS == `ATM_OFS_CTRL)
        begin
          wv = be_merge(32'(st.en), AVS_WRITEDATA, AVS_BYTEENABLE);
          next_st.en = wv[`ATM_CTRL_EN];
        end
        if (AVS_WRITE && AVS_ADDRESS == `ATM_OFS_SEL)
        begin
          wv = be_merge(32'(st.sel), AVS_WRITEDATA, AVS_BYTEENABLE);
          next_st.sel = wv[DW-1:0];
        end
      end
      default:
        next_st.bus = atm_pkg::BUS_WAIT;
    endcase

    if (clr)
    begin
      next_st.count = '0;
      next_st.full = 1'b0;
      next_st.ovf = '0;
      next_st.opn = '0;
    end
    ptr = int'(next_st.count);

    for (int s = 0; s < NS; s++)
    begin
      for (int d = 0; d < 2; d++)
      begin
        k = s * 2 + d;
        next_st.ovf[k*2] = next_st.ovf[k*2] | ovf_dep[k];
        next_st.ovf[k*2+1] = next_st.ovf[k*2+1] | ovf_ids[k];
        // Close: oldest open record with the same ID
        pick = -1;
        if (trk_cls[k])
          for (int m = 0; m < OPEN_N; m++)
            if (next_st.opn[k][m].busy &&
                next_st.opn[k][m].id == trk_cid[k])
              if (pick < 0 ||
                  next_st.opn[k][m].start < next_st.opn[k][pick].start)
                pick = m;
        if (pick >= 0)
        begin
          next_st.opn[k][pick].busy = 1'b0;
          recs[k].slot = 8'(s);
          recs[k].dir = (d == 1);
          recs[k].id = next_st.opn[k][pick].id;
          recs[k].addr = next_st.opn[k][pick].addr;
          recs[k].start = next_st.opn[k][pick].start;
          recs[k].fin = st.ts;
          recs[k].dur = st.ts - next_st.opn[k][pick].start;
          if (next_st.opn[k][pick].inwin && st.en)
          begin
            if (ptr < DEPTH)
            begin
              wen[k] = 1'b1;
              widx[k] = DW'(ptr);
              ptr = ptr + 1;
            end
            else
              next_st.full = 1'b1;
          end
        end
        // Open: each command takes its own record slot
        fr = -1;
        if (trk_opn[k])
        begin
          for (int m = OPEN_N - 1; m >= 0; m--)
            if (!next_st.opn[k][m].busy)
              fr = m;
          if (fr < 0)
            next_st.ovf[k*2+1] = 1'b1;
          else
          begin
            next_st.opn[k][fr].busy = 1'b1;
            next_st.opn[k][fr].inwin = st.en;
            next_st.opn[k][fr].id = trk_oid[k];
            next_st.opn[k][fr].addr = (d == 1) ? AXI_MON[s].awaddr
                                               : AXI_MON[s].araddr;
            next_st.opn[k][fr].start = st.ts;
          end
        end
      end
    end
    next_st.count = CW'(ptr);
  end

  // ----------------------------------------
  // Registers and record store
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      st <= '0;
      st.bus <= atm_pkg::BUS_WAIT;
      st.en <= `ATM_CTRL_RST;
    end
    else
      st <= next_st;
  end

  // Record memory holds no reset; the count says what is valid
  always_ff @(posedge CLK_SYS)
  begin
    for (int k = 0; k < NK; k++)
      if (wen[k])
        mem[widx[k]] <= recs[k];
  end

  assign AVS_WAITREQUEST = st.bus[0];
  assign AVS_READDATA = st.rdata;
  assign EVT = st.evt;

endmodule // atm_monitor

// >>> atm_monitor_sva.sv
// Checker for the AXI monitor: channel events of slot 0.
// Assumes a bind to atm_monitor; sees its ports only.
`timescale 1ns/1ps
module atm_monitor_sva #(
  parameter int NS = 2
) (
  // Clock and reset
  input wire logic                       CLK_SYS,
  input wire logic                       RST,
  // Watched bus and events
  input wire atm_pkg::atm_axi_s [NS-1:0] AXI_MON,
  input wire atm_pkg::atm_evt_s [NS-1:0] EVT
);
  wire atm_pkg::atm_axi_s a = AXI_MON[0];
  wire atm_pkg::atm_evt_s e = EVT[0];
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // ----------
  // Events lag the bus one cycle; the edge after reset is skipped
  // ----------
  sequence s_wfirst;
    !(a.wvalid && a.wready) ##1 (a.wvalid && a.wready && !a.wlast);
  endsequence
  sequence s_wrun;
    (a.wvalid && a.wready) [*2];
  endsequence
  property p_ar;
    !$past(RST) |-> e.ar_end == $past(a.arvalid && a.arready);
  endproperty
  a_ar: assert property (p_ar) else $error("bad ar_end");
  property p_aw;
    !$past(RST) |-> e.aw_end == $past(a.awvalid && a.awready);
  endproperty
  a_aw: assert property (p_aw) else $error("bad aw_end");
  property p_rb;
    !$past(RST) |-> e.r_beat == $past(a.rvalid && a.rready && !a.rlast);
  endproperty
  a_rb: assert property (p_rb) else $error("bad r_beat");
  property p_rl;
    !$past(RST) |-> e.r_last == $past(a.rvalid && a.rready && a.rlast);
  endproperty
  a_rl: assert property (p_rl) else $error("bad r_last");
  property p_wf;
    s_wfirst |=> e.w_beat;
  endproperty
  a_wf: assert property (p_wf) else $error("w_beat missing");
  property p_wr;
    s_wrun |=> !e.w_beat;
  endproperty
  a_wr: assert property (p_wr) else $error("w_beat repeated");
  property p_wl;
    !$past(RST) |-> e.w_last == $past(a.wvalid && a.wready && a.wlast);
  endproperty
  a_wl: assert property (p_wl) else $error("bad w_last");
  property p_b;
    !$past(RST) |-> e.b_resp == $past(a.bvalid && a.bready);
  endproperty
  a_b: assert property (p_b) else $error("bad b_resp");
endmodule // atm_monitor_sva

bind atm_monitor atm_monitor_sva #(.NS(NS)) u_sva (
  .CLK_SYS (CLK_SYS),
  .RST     (RST),
  .AXI_MON (AXI_MON),
  .EVT     (EVT)
);

// >>> atm_monitor_tb.sv
// Bench for the AXI monitor: slot traffic interleaved with register accesses.
// Assumes partner models drive slots 0 and 1.
`timescale 1ns/1ps
module atm_monitor_tb;
  logic        CLK_SYS = 1'b0;
  logic        RST = 1'b1;
  logic [7:0]  AVS_ADDRESS = 8'h00;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [31:0] q;
  int          fails = 0;
  int          check_count = 0;
  wire atm_pkg::atm_axi_s [1:0] mon;
  always #50 CLK_SYS = ~CLK_SYS;
  atm_axi_pm p0 (.clk(CLK_SYS), .axi(mon[0]));
  atm_axi_pm p1 (.clk(CLK_SYS), .axi(mon[1]));
  // Small counts so both overflow kinds and a full store are reachable
  atm_monitor #(.NS(2), .RD_OUT(2), .NCNT(2), .DEPTH(8)) dut (
    .CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AXI_MON(mon), .EVT()
  );
  // ----------
  // Tasks
  // ----------
  task automatic report_and_stop;
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic av(input logic wr, input logic [7:0] ad,
                    input logic [31:0] d);
    int n;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (AVS_WAITREQUEST !== 1'b0)
    begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] x);
    av(1'b0, ad, 32'h0);
    chk(q, x);
  endtask
  task automatic rec(input logic [31:0] k, input logic [31:0] inf,
                     input logic [31:0] ad, input logic [31:0] du);
    logic [31:0] s;
    av(1'b1, 8'h10, k);
    rd(8'h14, inf);
    rd(8'h18, ad);
    rd(8'h24, du);
    av(1'b0, 8'h1c, 32'h0);
    s = q;
    av(1'b0, 8'h20, 32'h0);
    chk(q - s, du);
  endtask
  // ----------
  // Sequence
  // ----------
  initial
  begin
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    av(1'b1, 8'h00, 32'h1);
    rd(8'h04, 32'h1);
    // A write with no byte lanes enabled must leave the enable alone
    AVS_BYTEENABLE <= 4'h0;
    av(1'b1, 8'h00, 32'h0);
    AVS_BYTEENABLE <= 4'hf;
    rd(8'h04, 32'h1);
    rd(8'h28, 32'h3ff);
    rd(8'h2c, 32'h0);
    p0.ar(4'h3, 32'h1000_0040, 2);
    p0.r(4'h5, 1);
    p0.r(4'h3, 2);
    p0.aw(4'h9, 32'h2000_0080);
    p0.w(3);
    p0.b(4'h9);
    p1.ar(4'h3, 32'h3000_0000, 0);
    p1.r(4'h3, 1);
    rd(8'h0c, 32'h3);
    rec(0, 32'h0003_0000, 32'h1000_0040, 32'd7);
    rec(1, 32'h0009_0001, 32'h2000_0080, 32'd6);
    rec(2, 32'h0003_0100, 32'h3000_0000, 32'd2);
    p0.ar(4'h7, 32'h5000_0000, 1);
    p0.ar(4'h7, 32'h5000_0100, 0);
    p0.r(4'h7, 1);
    p0.r(4'h7, 1);
    rd(8'h08, 32'h0);
    rec(3, 32'h0007_0000, 32'h5000_0000, 32'd5);
    rec(4, 32'h0007_0000, 32'h5000_0100, 32'd4);
    av(1'b1, 8'h00, 32'h0);
    p0.ar(4'h4, 32'h4000_0000, 0);
    av(1'b1, 8'h00, 32'h1);
    p0.r(4'h4, 1);
    rd(8'h0c, 32'h5);
    av(1'b1, 8'h00, 32'h3);
    p0.ar(4'h8, 32'h6000_0000, 0);
    p0.ar(4'h9, 32'h6000_0000, 0);
    rd(8'h08, 32'h0);
    av(1'b1, 8'h00, 32'h3);
    repeat (3) p0.ar(4'h7, 32'h7000_0000, 0);
    rd(8'h08, 32'h1);
    av(1'b1, 8'h00, 32'h3);
    rd(8'h08, 32'h0);
    // Eight records fit; the ninth is dropped and sets the full flag
    repeat (9)
    begin
      p0.ar(4'h6, 32'h9000_0000, 0);
      p0.r(4'h6, 1);
    end
    rd(8'h0c, 32'h8);
    rd(8'h04, 32'h3);
    for (int i = 1; i <= 3; i++)
      p0.ar(4'(i), 32'h8000_0000, 0);
    rd(8'h08, 32'h2);
    report_and_stop();
  end
endmodule // atm_monitor_tb

// >>> atm_params.svh
// Offsets, field positions, reset values and widths for the AXI monitor.
// Assumes inclusion by atm_pkg, by the design modules and by the partner model atm_axi_pm.
`ifndef ATM_PARAMS_SVH
`define ATM_PARAMS_SVH

// ----------------------------------------
// Widths of the monitored bus and of the timestamps
// ----------------------------------------
`define ATM_ID_W     4
`define ATM_ADDR_W   32
`define ATM_TS_W     32

// ----------------------------------------
// Default capacities
// ----------------------------------------
`define ATM_RD_OUT   4
`define ATM_WR_OUT   4
`define ATM_NCNT     4
`define ATM_OPEN_N   8
`define ATM_DEPTH    16

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ATM_OFS_CTRL  8'h00
`define ATM_OFS_STAT  8'h04
`define ATM_OFS_OVF   8'h08
`define ATM_OFS_CNT   8'h0c
`define ATM_OFS_SEL   8'h10
`define ATM_OFS_INFO  8'h14
`define ATM_OFS_ADDR  8'h18
`define ATM_OFS_START 8'h1c
`define ATM_OFS_END   8'h20
`define ATM_OFS_DUR   8'h24
`define ATM_OFS_IDLE  8'h28

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ATM_CTRL_EN   0
`define ATM_CTRL_CLR  1
`define ATM_STAT_FULL 1
`define ATM_CTRL_RST  1'b0

`endif

// >>> atm_pkg.sv
// Types shared by the AXI monitor modules.
// Assumes atm_params.svh is on the include path.
`include "atm_params.svh"

package atm_pkg;

  // ----------------------------------------
  // Monitored bus and events
  // ----------------------------------------
  typedef struct packed {
    logic                   arvalid;
    logic                   arready;
    logic [`ATM_ID_W-1:0]   arid;
    logic [`ATM_ADDR_W-1:0] araddr;
    logic                   rvalid;
    logic                   rready;
    logic                   rlast;
    logic [`ATM_ID_W-1:0]   rid;
    logic                   awvalid;
    logic                   awready;
    logic [`ATM_ID_W-1:0]   awid;
    logic [`ATM_ADDR_W-1:0] awaddr;
    logic                   wvalid;
    logic                   wready;
    logic                   wlast;
    logic                   bvalid;
    logic                   bready;
    logic [`ATM_ID_W-1:0]   bid;
  } atm_axi_s;

  typedef struct packed {
    logic ar_start;
    logic ar_cmd;
    logic ar_end;
    logic ar_idle;
    logic r_beat;
    logic r_last;
    logic r_idle;
    logic aw_start;
    logic aw_cmd;
    logic aw_end;
    logic aw_idle;
    logic w_beat;
    logic w_last;
    logic w_idle;
    logic b_resp;
    logic b_idle;
  } atm_evt_s;

  // ----------------------------------------
  // Transaction records and the register bus handshake state
  // ----------------------------------------
  typedef struct packed {
    logic                   busy;
    logic                   inwin;
    logic [`ATM_ID_W-1:0]   id;
    logic [`ATM_ADDR_W-1:0] addr;
    logic [`ATM_TS_W-1:0]   start;
  } atm_open_s;

  typedef struct packed {
    logic [7:0]             slot;
    logic                   dir;
    logic [`ATM_ID_W-1:0]   id;
    logic [`ATM_ADDR_W-1:0] addr;
    logic [`ATM_TS_W-1:0]   start;
    logic [`ATM_TS_W-1:0]   fin;
    logic [`ATM_TS_W-1:0]   dur;
  } atm_rec_s;

  typedef enum logic [1:0] {
    BUS_WAIT = 2'b01,
    BUS_ACK  = 2'b10
  } atm_bus_e;

endpackage

// >>> atm_trk.sv
// Per-ID outstanding transaction counters for one slot and direction.
// Assumes at most one open and one close per cycle.
`timescale 1ns/1ps
`include "atm_params.svh"

module atm_trk #(
  parameter int CAP  = `ATM_RD_OUT,
  parameter int NCNT = `ATM_NCNT
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 clr,
  // Open and close
  input  wire logic                 opn,
  input  wire logic [`ATM_ID_W-1:0] opn_id,
  input  wire logic                 cls,
  input  wire logic [`ATM_ID_W-1:0] cls_id,
  // Overflow pulses
  output logic                      ovf_depth,
  output logic                      ovf_ids
);

  localparam int CW = $clog2(CAP + 1);

  typedef struct packed {
    logic [NCNT-1:0]                used;
    logic [NCNT-1:0][`ATM_ID_W-1:0] id;
    logic [NCNT-1:0][CW-1:0]        cnt;
  } atm_trk_st_s;

  atm_trk_st_s st;
  atm_trk_st_s next_st;

  function automatic int find_id(input atm_trk_st_s s,
                                 input logic [`ATM_ID_W-1:0] id);
    int r;
    r = -1;
    for (int i = NCNT - 1; i >= 0; i--)
      if (s.used[i] && s.id[i] == id)
        r = i;
    return r;
  endfunction

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  always_comb
  begin
    int hit;
    int fr;
    hit = -1;
    fr = -1;
    // Clear first: an open in the clearing cycle must still be counted,
    // or the open-record table and this counter drift apart
    next_st = clr ? '0 : st;
    ovf_depth = 1'b0;
    ovf_ids = 1'b0;
    begin
      if (cls)
      begin
        hit = find_id(next_st, cls_id);
        if (hit >= 0)
        begin
          next_st.cnt[hit] = next_st.cnt[hit] - CW'(1);
          if (next_st.cnt[hit] == '0)
            next_st.used[hit] = 1'b0;
        end
      end
      if (opn)
      begin
        hit = find_id(next_st, opn_id);
        if (hit >= 0)
        begin
          if (next_st.cnt[hit] == CW'(CAP))
            ovf_depth = 1'b1;
          else
            next_st.cnt[hit] = next_st.cnt[hit] + CW'(1);
        end
        else
        begin
          for (int i = NCNT - 1; i >= 0; i--)
            if (!next_st.used[i])
              fr = i;
          if (fr < 0)
            ovf_ids = 1'b1;
          else
          begin
            next_st.used[fr] = 1'b1;
            next_st.id[fr] = opn_id;
            next_st.cnt[fr] = CW'(1);
          end
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

endmodule // atm_trk
